/* mie_apb_host.sv */
// APB master model that stands in for software on the register bus
`timescale 1ns/100ps
module mie_apb_host (
  // Clock
  input  wire logic        pclk,
  // APB request
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  // APB answer
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr
);
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0000_0000;
  end

  // ---------------------------------------------------------------
  // One transfer, held until pready is sampled high
  // ---------------------------------------------------------------
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err, output logic ok);
    ok  = 1'b0;
    q   = 32'h0;
    err = 1'b0;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Bounded so a slave that never answers cannot hang the run
    for (int n = 0; n < 16 && !ok; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) begin
        q   = prdata;
        err = pslverr;
        ok  = 1'b1;
      end
    end
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : mie_apb_host

/* mie_core.sv */
// Instruction execute datapath with APB command and memory window access
`timescale 1ns/100ps
`include "mie_defines.svh"

// What this block does
// - copy-skip-if-zero loads byte into accumulator; zero byte skips, two cycles.
// - skip-if-zero on bit skips when selected bit is zero; no flags change.
// - paged table read uses high:low pointers; low byte to memory, high to latch.
// - incrementing paged table read bumps low pointer first, then reads.
// - incrementing last-page table read bumps low pointer first, then reads.
// - XOR forms combine accumulator with byte or immediate; only zero flag changes.
// - extended forms address any data memory byte directly, any section.
// - add-with-carry sums acc, byte, carry; sets OV, Z, AC, C, SC.
// - add sums acc and byte, no carry in; same five flags.
// - AND of acc and byte; only zero flag changes.
// - OR of acc and byte; only zero flag changes.
// - clear writes 00H to byte or zero to one bit; flags kept.
// - invert byte to memory or accumulator; zero flag updated.
// - decimal adjust acc by nibble fixes into byte; only carry changes.
// - decrement byte to memory or accumulator; zero flag updated.
// - increment byte to memory or accumulator; zero flag updated.
// - move byte to acc or acc to byte; no flags change.
// - rotate left feeds old bit 7 into bit 0, written back.
module mie_core
  import mie_pkg::*;
#(
  parameter int DADDR_W = 10,
  parameter int PADDR_W = 12
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Execution status
  output logic             busy,
  output logic             skip_next
);
  import mie_pkg::*;

  // ------------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------------
  localparam int DDEPTH = 1 << DADDR_W;
  localparam int PDEPTH = 1 << PADDR_W;
  logic [7:0]  dmem [DDEPTH];
  logic [15:0] pmem [PDEPTH];

  logic [7:0]  accumulator_reg;
  logic [4:0]  flags_reg;
  logic [7:0]  table_pointer_low_reg;
  logic [7:0]  table_pointer_high_reg;
  logic [7:0]  table_high_latch_reg;
  mie_state_t  state_reg;
  mie_op_t     op_reg;
  logic [DADDR_W-1:0] adr_reg;
  logic [2:0]  bit_reg;
  logic [7:0]  imm_reg;
  logic [7:0]  cycles_reg;

  wire logic access = psel && penable;
  // Register writes land only at the edge that completes the transfer, never a cycle early
  wire logic wr_en  = access && pwrite && pready;
  wire logic cmd_wr = wr_en && (paddr == `MIE_OFF_CMD) && (state_reg == MIE_IDLE);

  // ------------------------------------------------------------------
  // Datapath
  // ------------------------------------------------------------------
  logic [7:0] mval;
  logic [7:0] res;
  logic       wr_mem;
  logic       wr_acc;
  logic [4:0] flags_next;
  logic       skip;
  logic [8:0] sum;
  logic [4:0] lsum;
  logic       cin;
  logic [8:0] daa;
  logic [PADDR_W-1:0] paddr_rd;
  logic [7:0] tpl_next;
  logic       tbl_rd;
  logic       tpl_inc;
  logic [15:0] pword;

  // Extended forms take a full data address, so every section is reachable
  assign mval = dmem[adr_reg];

  always_comb begin
    res        = mval;
    wr_mem     = 1'b0;
    wr_acc     = 1'b0;
    flags_next = flags_reg;
    skip       = 1'b0;
    tbl_rd     = 1'b0;
    tpl_inc    = 1'b0;
    cin        = 1'b0;
    sum        = 9'h000;
    lsum       = 5'h00;
    daa        = 9'h000;
    case (op_reg)
      MIE_COPY_SKIP_IF_ZERO: begin
        wr_acc = 1'b1;
        skip   = (mval == 8'h00);
      end
      MIE_SKIP_IF_ZERO: skip = !mval[bit_reg];
      MIE_TABLE_READ_PAGED, MIE_TABLE_READ_LAST_PAGE: tbl_rd = 1'b1;
      MIE_INCR_TABLE_READ_PAGED, MIE_INCR_TABLE_READ_LAST_PAGE: begin
        tbl_rd  = 1'b1;
        tpl_inc = 1'b1;
      end
      MIE_XOR_ACC, MIE_EXCLUSIVE_OR_TO_MEMORY, MIE_XOR_IMM: begin
        res = accumulator_reg ^ ((op_reg == MIE_XOR_IMM) ? imm_reg : mval);
        wr_mem = (op_reg == MIE_EXCLUSIVE_OR_TO_MEMORY);
        wr_acc = !wr_mem;
        flags_next[`MIE_FLAG_Z] = (res == 8'h00);
      end
      MIE_EXT_ADD_WITH_CARRY, MIE_EXT_ADD_WITH_CARRY_TO_MEMORY,
      MIE_EXT_ADD, MIE_EXT_ADD_TO_MEMORY: begin
        cin = (op_reg == MIE_EXT_ADD_WITH_CARRY || op_reg == MIE_EXT_ADD_WITH_CARRY_TO_MEMORY)
              ? flags_reg[`MIE_FLAG_C] : 1'b0;
        sum  = {1'b0, accumulator_reg} + {1'b0, mval} + {8'h00, cin};
        lsum = {1'b0, accumulator_reg[3:0]} + {1'b0, mval[3:0]} + {4'h0, cin};
        res  = sum[7:0];
        wr_mem = (op_reg == MIE_EXT_ADD_WITH_CARRY_TO_MEMORY || op_reg == MIE_EXT_ADD_TO_MEMORY);
        wr_acc = !wr_mem;
        flags_next[`MIE_FLAG_C]  = sum[8];
        flags_next[`MIE_FLAG_AC] = lsum[4];
        flags_next[`MIE_FLAG_Z]  = (sum[7:0] == 8'h00);
        flags_next[`MIE_FLAG_OV] = (accumulator_reg[7] == mval[7]) && (sum[7] != mval[7]);
        flags_next[`MIE_FLAG_SC] = sum[7] ^ flags_next[`MIE_FLAG_OV];
      end
      MIE_EXT_BITWISE_CONJ, MIE_EXT_BITWISE_CONJ_TO_MEMORY: begin
        res = accumulator_reg & mval;
        wr_mem = (op_reg == MIE_EXT_BITWISE_CONJ_TO_MEMORY);
        wr_acc = !wr_mem;
        flags_next[`MIE_FLAG_Z] = (res == 8'h00);
      end
      MIE_EXT_BITWISE_DISJ, MIE_EXT_BITWISE_DISJ_TO_MEMORY: begin
        res = accumulator_reg | mval;
        wr_mem = (op_reg == MIE_EXT_BITWISE_DISJ_TO_MEMORY);
        wr_acc = !wr_mem;
        flags_next[`MIE_FLAG_Z] = (res == 8'h00);
      end
      MIE_EXT_CLEAR: begin
        res    = `MIE_RST_BYTE;
        wr_mem = 1'b1;
      end
      MIE_EXT_CLEAR_BIT: begin
        res          = mval;
        res[bit_reg] = 1'b0;
        wr_mem       = 1'b1;
      end
      MIE_EXT_INVERT, MIE_EXT_INVERT_TO_ACC: begin
        res = ~mval;
        wr_mem = (op_reg == MIE_EXT_INVERT);
        wr_acc = !wr_mem;
        flags_next[`MIE_FLAG_Z] = (res == 8'h00);
      end
      MIE_EXT_DECIMAL_ADJUST: begin
        daa = {1'b0, accumulator_reg};
        if (daa[3:0] > `MIE_BCD_LIMIT || flags_reg[`MIE_FLAG_AC]) begin
          daa = daa + {5'h00, `MIE_BCD_FIX};
        end
        if (daa[7:4] > `MIE_BCD_LIMIT || daa[8] || flags_reg[`MIE_FLAG_C]) begin
          daa = daa + {1'b0, `MIE_BCD_FIX, 4'h0};
        end
        res    = daa[7:0];
        wr_mem = 1'b1;
        flags_next[`MIE_FLAG_C] = daa[8] || flags_reg[`MIE_FLAG_C];
      end
      MIE_EXT_DECREMENT, MIE_EXT_DECREMENT_TO_ACC: begin
        res = mval - 8'h01;
        wr_mem = (op_reg == MIE_EXT_DECREMENT);
        wr_acc = !wr_mem;
        flags_next[`MIE_FLAG_Z] = (res == 8'h00);
      end
      MIE_EXT_INCREMENT, MIE_EXT_INCREMENT_TO_ACC: begin
        res = mval + 8'h01;
        wr_mem = (op_reg == MIE_EXT_INCREMENT);
        wr_acc = !wr_mem;
        flags_next[`MIE_FLAG_Z] = (res == 8'h00);
      end
      MIE_EXT_MOVE_TO_ACC: wr_acc = 1'b1;
      MIE_EXT_MOVE_TO_MEM: begin
        res    = accumulator_reg;
        wr_mem = 1'b1;
      end
      MIE_EXT_ROTATE_LEFT: begin
        res    = {mval[6:0], mval[7]};
        wr_mem = 1'b1;
      end
      default: res = mval;
    endcase
  end

  // Table address: increment of the low pointer is seen by this same read
  assign tpl_next = tpl_inc ? table_pointer_low_reg + 8'h01 : table_pointer_low_reg;
  always_comb begin
    if (op_reg == MIE_TABLE_READ_LAST_PAGE || op_reg == MIE_INCR_TABLE_READ_LAST_PAGE) begin
      paddr_rd = {{(PADDR_W-8){1'b1}}, tpl_next};
    end else begin
      paddr_rd = PADDR_W'({table_pointer_high_reg, tpl_next});
    end
  end
  assign pword = pmem[paddr_rd];

  wire logic exec = (state_reg == MIE_EXEC);

  // ------------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= MIE_IDLE;
      op_reg    <= MIE_NOP;
      adr_reg   <= '0;
      bit_reg   <= 3'h0;
      imm_reg   <= 8'h00;
    end else begin
      case (state_reg)
        MIE_IDLE: if (cmd_wr) begin
          op_reg    <= mie_op_t'(pwdata[`MIE_CMD_OP_LSB +: 8]);
          adr_reg   <= pwdata[`MIE_CMD_ADR_LSB +: DADDR_W];
          bit_reg   <= pwdata[`MIE_CMD_BIT_LSB +: 3];
          imm_reg   <= pwdata[`MIE_CMD_IMM_LSB +: 8];
          state_reg <= MIE_EXEC;
        end
        // A taken skip costs one dummy cycle, two in all
        MIE_EXEC:  state_reg <= skip ? MIE_DUMMY : MIE_IDLE;
        MIE_DUMMY: state_reg <= MIE_IDLE;
        default:   state_reg <= MIE_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy       <= 1'b0;
      skip_next  <= 1'b0;
      cycles_reg <= 8'h00;
    end else begin
      busy <= cmd_wr || (exec && skip);
      if (exec) begin
        skip_next  <= skip;
        cycles_reg <= skip ? 8'(`MIE_SKIP_CYCLES) : 8'h01;
      end
    end
  end

  // ------------------------------------------------------------------
  // Architectural state
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      accumulator_reg        <= `MIE_RST_BYTE;
      flags_reg              <= 5'h00;
      table_pointer_low_reg  <= `MIE_RST_BYTE;
      table_pointer_high_reg <= `MIE_RST_BYTE;
      table_high_latch_reg   <= `MIE_RST_BYTE;
    end else if (exec) begin
      if (wr_acc) accumulator_reg <= res;
      flags_reg <= flags_next;
      table_pointer_low_reg <= tpl_next;
      if (tbl_rd) table_high_latch_reg <= pword[15:8];
    end else if (wr_en && state_reg == MIE_IDLE) begin
      if (paddr == `MIE_OFF_ACC) begin
        accumulator_reg <= pwdata[7:0];
      end else if (paddr == `MIE_OFF_FLAGS) begin
        flags_reg <= pwdata[4:0];
      end else if (paddr == `MIE_OFF_TBL) begin
        table_pointer_low_reg  <= pwdata[7:0];
        table_pointer_high_reg <= pwdata[15:8];
      end
    end
  end

  // Memories have no reset; software loads them through the windows
  always_ff @(posedge pclk) begin
    if (exec && tbl_rd) begin
      dmem[adr_reg] <= pword[7:0];
    end else if (exec && wr_mem) begin
      dmem[adr_reg] <= res;
    end else if (wr_en && paddr[11:10] == 2'b01) begin
      dmem[DADDR_W'(paddr[9:2])] <= pwdata[7:0];
    end
    if (wr_en && paddr[11] && !exec) begin
      pmem[PADDR_W'(paddr[10:2])] <= pwdata[15:0];
    end
  end

  // ------------------------------------------------------------------
  // APB read side
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      // One wait state: answer a cycle after the access phase opens
      pready  <= psel && penable && !pready;
      pslverr <= 1'b0;
      if (psel && penable && !pready && !pwrite) begin
        if (paddr == `MIE_OFF_CMD) begin
          prdata <= {24'h0, op_reg};
        end else if (paddr == `MIE_OFF_ACC) begin
          prdata <= {24'h0, accumulator_reg};
        end else if (paddr == `MIE_OFF_FLAGS) begin
          prdata <= {27'h0, flags_reg};
        end else if (paddr == `MIE_OFF_TBL) begin
          prdata <= {16'h0, table_pointer_high_reg, table_pointer_low_reg};
        end else if (paddr == `MIE_OFF_TABLE_HIGH_LATCH) begin
          prdata <= {24'h0, table_high_latch_reg};
        end else if (paddr == `MIE_OFF_STATUS) begin
          prdata <= {16'h0, cycles_reg, 6'h0, skip_next, busy};
        end else if (paddr[11:10] == 2'b01) begin
          prdata <= {24'h0, dmem[DADDR_W'(paddr[9:2])]};
        end else if (paddr[11]) begin
          prdata <= {16'h0, pmem[PADDR_W'(paddr[10:2])]};
        end else begin
          prdata  <= 32'h0000_0000;
          pslverr <= 1'b1;
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  skip_two_cyc_a: assert property (@(posedge pclk) disable iff (!presetn)
    exec && skip |=> state_reg == MIE_DUMMY ##1 state_reg == MIE_IDLE)
    else $error("skip did not take two cycles");
  copy_acc_a: assert property (@(posedge pclk) disable iff (!presetn)
    exec && op_reg == MIE_COPY_SKIP_IF_ZERO |=> accumulator_reg == $past(mval))
    else $error("copy did not load accumulator");
  bit_skip_a: assert property (@(posedge pclk) disable iff (!presetn)
    exec && op_reg == MIE_SKIP_IF_ZERO |=> skip_next == !$past(mval[bit_reg])
      && flags_reg == $past(flags_reg))
    else $error("bit skip wrong");
  tbl_latch_a: assert property (@(posedge pclk) disable iff (!presetn)
    exec && tbl_rd |=> table_high_latch_reg == $past(pword[15:8]))
    else $error("table high latch wrong");
  tbl_incr_a: assert property (@(posedge pclk) disable iff (!presetn)
    exec && tpl_inc |=> table_pointer_low_reg == $past(table_pointer_low_reg) + 8'h01)
    else $error("table pointer not incremented");
  xor_res_a: assert property (@(posedge pclk) disable iff (!presetn)
    exec && op_reg == MIE_XOR_ACC |=> accumulator_reg == ($past(accumulator_reg)
      ^ $past(mval)) && flags_reg[`MIE_FLAG_C] == $past(flags_reg[`MIE_FLAG_C]))
    else $error("xor result wrong");
  add_carry_a: assert property (@(posedge pclk) disable iff (!presetn)
    exec && op_reg == MIE_EXT_ADD_WITH_CARRY |=> {flags_reg[`MIE_FLAG_C], accumulator_reg}
      == $past({1'b0, accumulator_reg} + {1'b0, mval} + {8'h00, flags_reg[`MIE_FLAG_C]}))
    else $error("add with carry wrong");
  move_flags_a: assert property (@(posedge pclk) disable iff (!presetn)
    exec && (op_reg == MIE_EXT_MOVE_TO_ACC || op_reg == MIE_EXT_CLEAR)
      |=> $stable(flags_reg))
    else $error("flags changed on move or clear");
  daa_flags_a: assert property (@(posedge pclk) disable iff (!presetn)
    exec && op_reg == MIE_EXT_DECIMAL_ADJUST
      |=> flags_reg[4:1] == $past(flags_reg[4:1]) && accumulator_reg == $past(accumulator_reg))
    else $error("decimal adjust touched other state");
endmodule : mie_core

/* mie_core_tb_top.sv */
// Self-checking bench for the instruction execute block
`timescale 1ns/100ps
`include "mie_defines.svh"
module mie_core_tb_top;
  import mie_pkg::*;
  // Op, acc in, byte in, bit, immediate, flags in, result, result to byte, flags out, skip
  typedef struct packed {
    mie_op_t op; logic [7:0] a; logic [7:0] m; logic [2:0] bn; logic [7:0] imm;
    logic [4:0] fin; logic [7:0] res; logic mem; logic [4:0] fout; logic skp;
  } mie_case_t;
  typedef struct packed {
    mie_op_t op; logic [7:0] hi; logic [7:0] lo; logic inc; logic [15:0] w;
  } mie_tcase_t;
  // Flags are {sign compare, overflow, zero, aux carry, carry}
  localparam mie_case_t CASES [28] = '{
    '{MIE_COPY_SKIP_IF_ZERO,8'h55,8'h00,3'd0,8'h00,5'h1b,8'h00,1'b0,5'h1b,1'b1},
    '{MIE_COPY_SKIP_IF_ZERO,8'h55,8'h3c,3'd0,8'h00,5'h1b,8'h3c,1'b0,5'h1b,1'b0},
    '{MIE_SKIP_IF_ZERO,8'h55,8'h3c,3'd1,8'h00,5'h04,8'h3c,1'b1,5'h04,1'b1},
    '{MIE_SKIP_IF_ZERO,8'h55,8'h3c,3'd2,8'h00,5'h04,8'h3c,1'b1,5'h04,1'b0},
    '{MIE_XOR_ACC,8'ha5,8'ha5,3'd0,8'h00,5'h1b,8'h00,1'b0,5'h1f,1'b0},
    '{MIE_EXCLUSIVE_OR_TO_MEMORY,8'h0f,8'hff,3'd0,8'h00,5'h1f,8'hf0,1'b1,5'h1b,1'b0},
    '{MIE_XOR_IMM,8'h3c,8'h77,3'd0,8'h3c,5'h1b,8'h00,1'b0,5'h1f,1'b0},
    '{MIE_EXT_ADD_WITH_CARRY,8'h38,8'h47,3'd0,8'h00,5'h05,8'h80,1'b0,5'h0a,1'b0},
    '{MIE_EXT_ADD_WITH_CARRY_TO_MEMORY,8'h80,8'h80,3'd0,8'h00,5'h02,8'h00,1'b1,5'h1d,1'b0},
    '{MIE_EXT_ADD,8'h7f,8'h01,3'd0,8'h00,5'h01,8'h80,1'b0,5'h0a,1'b0},
    '{MIE_EXT_ADD_TO_MEMORY,8'hff,8'h01,3'd0,8'h00,5'h18,8'h00,1'b1,5'h07,1'b0},
    '{MIE_EXT_BITWISE_CONJ,8'hf0,8'h0f,3'd0,8'h00,5'h1b,8'h00,1'b0,5'h1f,1'b0},
    '{MIE_EXT_BITWISE_CONJ_TO_MEMORY,8'hf3,8'h3f,3'd0,8'h00,5'h1f,8'h33,1'b1,5'h1b,1'b0},
    '{MIE_EXT_BITWISE_DISJ,8'h00,8'h00,3'd0,8'h00,5'h1b,8'h00,1'b0,5'h1f,1'b0},
    '{MIE_EXT_BITWISE_DISJ_TO_MEMORY,8'h50,8'h05,3'd0,8'h00,5'h04,8'h55,1'b1,5'h00,1'b0},
    '{MIE_EXT_CLEAR,8'h55,8'ha5,3'd0,8'h00,5'h1f,8'h00,1'b1,5'h1f,1'b0},
    '{MIE_EXT_CLEAR_BIT,8'h55,8'hff,3'd3,8'h00,5'h00,8'hf7,1'b1,5'h00,1'b0},
    '{MIE_EXT_INVERT,8'h55,8'h5a,3'd0,8'h00,5'h04,8'ha5,1'b1,5'h00,1'b0},
    '{MIE_EXT_INVERT_TO_ACC,8'h55,8'hff,3'd0,8'h00,5'h1b,8'h00,1'b0,5'h1f,1'b0},
    '{MIE_EXT_DECIMAL_ADJUST,8'ha2,8'h55,3'd0,8'h00,5'h1c,8'h02,1'b1,5'h1d,1'b0},
    '{MIE_EXT_DECIMAL_ADJUST,8'h3c,8'h55,3'd0,8'h00,5'h01,8'ha2,1'b1,5'h01,1'b0},
    '{MIE_EXT_DECREMENT,8'h55,8'h01,3'd0,8'h00,5'h1b,8'h00,1'b1,5'h1f,1'b0},
    '{MIE_EXT_DECREMENT_TO_ACC,8'h55,8'h00,3'd0,8'h00,5'h04,8'hff,1'b0,5'h00,1'b0},
    '{MIE_EXT_INCREMENT,8'h55,8'hff,3'd0,8'h00,5'h00,8'h00,1'b1,5'h04,1'b0},
    '{MIE_EXT_INCREMENT_TO_ACC,8'h55,8'h7f,3'd0,8'h00,5'h1f,8'h80,1'b0,5'h1b,1'b0},
    '{MIE_EXT_MOVE_TO_ACC,8'h77,8'h00,3'd0,8'h00,5'h1b,8'h00,1'b0,5'h1b,1'b0},
    '{MIE_EXT_MOVE_TO_MEM,8'h77,8'h00,3'd0,8'h00,5'h1b,8'h77,1'b1,5'h1b,1'b0},
    '{MIE_EXT_ROTATE_LEFT,8'h55,8'h81,3'd0,8'h00,5'h00,8'h03,1'b1,5'h00,1'b0}
  };
  // Words placed at 0x020 and 0x120; the last page is the top page of a 9-bit space
  localparam mie_tcase_t TCASES [5] = '{
    '{MIE_TABLE_READ_PAGED,8'h00,8'h20,1'b0,16'ha1b2},
    '{MIE_TABLE_READ_PAGED,8'h01,8'h20,1'b0,16'hbeef},
    '{MIE_TABLE_READ_LAST_PAGE,8'h00,8'h20,1'b0,16'hbeef},
    '{MIE_INCR_TABLE_READ_PAGED,8'h00,8'h1f,1'b1,16'ha1b2},
    '{MIE_INCR_TABLE_READ_LAST_PAGE,8'h00,8'h1f,1'b1,16'hbeef}
  };
  localparam logic [11:0] RST_ADR [5] = '{`MIE_OFF_ACC, `MIE_OFF_FLAGS, `MIE_OFF_TBL,
                                          `MIE_OFF_TABLE_HIGH_LATCH, `MIE_OFF_STATUS};
  logic        pclk;
  logic        presetn;
  logic        psel, penable, pwrite, pready, pslverr, busy, skip_next;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  int          fail_count;
  int          compares;

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  mie_core #(.DADDR_W(10), .PADDR_W(9)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .busy(busy), .skip_next(skip_next));
  mie_apb_host host_u (
    .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic report_and_stop();
    if (fail_count == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    logic ok;
    host_u.xfer(w, a, d, q, err, ok);
    if (!ok) begin
      fail_count++;
      report_and_stop();
    end
  endtask : bus

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    bus(1'b1, a, d, q, e);
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    logic e;
    bus(1'b0, a, 32'h0, q, e);
  endtask : rd

  function automatic logic [11:0] dm(input logic [7:0] i);
    return `MIE_OFF_DMEM + {2'b00, i, 2'b00};
  endfunction : dm

  // Commands are refused while busy, so every command waits for idle
  task automatic exec(input logic [31:0] cmd, input logic skp);
    logic [31:0] q;
    int          n;
    wr(`MIE_OFF_CMD, cmd);
    // Busy rises at the completing edge and stays through the dummy cycle of a skip
    @(posedge pclk);
    chk("busy after command", 32'h1, {31'h0, busy});
    @(posedge pclk);
    chk("busy in dummy cycle", {31'h0, skp}, {31'h0, busy});
    for (n = 0; n < 8; n++) begin
      rd(`MIE_OFF_STATUS, q);
      if (q[0] === 1'b0) break;
    end
    if (n == 8) begin
      fail_count++;
      report_and_stop();
    end
  endtask : exec

  task automatic run_case(input mie_case_t c, input logic [7:0] adr);
    logic [31:0] q;
    wr(`MIE_OFF_ACC, {24'h0, c.a});
    wr(`MIE_OFF_FLAGS, {27'h0, c.fin});
    wr(dm(adr), {24'h0, c.m});
    exec({c.imm, 1'b0, c.bn, 4'h0, adr, c.op}, c.skp);
    rd(`MIE_OFF_ACC, q);
    chk("accumulator", {24'h0, c.mem ? c.a : c.res}, q & 32'hff);
    rd(dm(adr), q);
    chk("data byte", {24'h0, c.mem ? c.res : c.m}, q & 32'hff);
    rd(`MIE_OFF_FLAGS, q);
    chk("flags", {27'h0, c.fout}, q & 32'h1f);
    rd(`MIE_OFF_STATUS, q);
    chk("status", {16'h0, c.skp ? 8'h02 : 8'h01, 6'h0, c.skp, 1'b0}, q & 32'hff03);
    chk("skip port", {31'h0, c.skp}, {31'h0, skip_next});
    chk("busy port", 32'h0, {31'h0, busy});
  endtask : run_case

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic s_reset();
    logic [31:0] q;
    logic        e;
    for (int i = 0; i < 5; i++) begin
      rd(RST_ADR[i], q);
      chk("reset value", 32'h0, q);
    end
    bus(1'b0, 12'h01c, 32'h0, q, e);
    chk("unmapped error", 32'h1, {31'h0, e});
  endtask : s_reset

  task automatic s_cases();
    for (int i = 0; i < 28; i++) begin
      run_case(CASES[i], 8'(i * 9 + 3));
    end
  endtask : s_cases

  task automatic s_table();
    logic [31:0] q;
    mie_tcase_t  t;
    wr(`MIE_OFF_PMEM + 12'h080, 32'h0000a1b2);
    wr(`MIE_OFF_PMEM + 12'h480, 32'h0000beef);
    for (int i = 0; i < 5; i++) begin
      t = TCASES[i];
      wr(`MIE_OFF_TBL, {16'h0, t.hi, t.lo});
      exec({16'h0, 8'hc0, t.op}, 1'b0);
      rd(dm(8'hc0), q);
      chk("table low byte", {24'h0, t.w[7:0]}, q & 32'hff);
      rd(`MIE_OFF_TABLE_HIGH_LATCH, q);
      chk("table high latch", {24'h0, t.w[15:8]}, q & 32'hff);
      rd(`MIE_OFF_TBL, q);
      chk("table pointer", {16'h0, t.hi, t.lo + 8'(t.inc)}, q & 32'hffff);
    end
  endtask : s_table

  initial begin
    fail_count = 0;
    compares   = 0;
    presetn    = 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    s_reset();
    s_cases();
    s_table();
    report_and_stop();
  end
endmodule : mie_core_tb_top

/* mie_defines.svh */
// Constants for the instruction execute block: register offsets, fields, resets
`ifndef MIE_DEFINES_SVH
`define MIE_DEFINES_SVH
`define MIE_OFF_CMD     12'h000
`define MIE_OFF_ACC     12'h004
`define MIE_OFF_FLAGS   12'h008
`define MIE_OFF_TBL     12'h00c
`define MIE_OFF_TABLE_HIGH_LATCH    12'h010
`define MIE_OFF_STATUS  12'h014
`define MIE_OFF_DMEM    12'h400
`define MIE_OFF_PMEM    12'h800
`define MIE_FLAG_C      0
`define MIE_FLAG_AC     1
`define MIE_FLAG_Z      2
`define MIE_FLAG_OV     3
`define MIE_FLAG_SC     4
`define MIE_CMD_OP_LSB  0
`define MIE_CMD_ADR_LSB 8
`define MIE_CMD_BIT_LSB 20
`define MIE_CMD_IMM_LSB 24
`define MIE_RST_BYTE    8'h00
`define MIE_RST_WORD    16'h0000
`define MIE_BCD_LIMIT   4'h9
`define MIE_BCD_FIX     4'h6
`define MIE_SKIP_CYCLES 2
`endif

/* mie_pkg.sv */
// Types for the instruction execute block
package mie_pkg;
  typedef enum logic [7:0] {
    MIE_NOP, MIE_COPY_SKIP_IF_ZERO, MIE_SKIP_IF_ZERO, MIE_TABLE_READ_PAGED,
    MIE_TABLE_READ_LAST_PAGE, MIE_INCR_TABLE_READ_PAGED, MIE_INCR_TABLE_READ_LAST_PAGE,
    MIE_XOR_ACC, MIE_EXCLUSIVE_OR_TO_MEMORY, MIE_XOR_IMM,
    MIE_EXT_ADD_WITH_CARRY, MIE_EXT_ADD_WITH_CARRY_TO_MEMORY, MIE_EXT_ADD,
    MIE_EXT_ADD_TO_MEMORY, MIE_EXT_BITWISE_CONJ, MIE_EXT_BITWISE_CONJ_TO_MEMORY,
    MIE_EXT_CLEAR, MIE_EXT_CLEAR_BIT, MIE_EXT_INVERT, MIE_EXT_INVERT_TO_ACC,
    MIE_EXT_DECIMAL_ADJUST, MIE_EXT_DECREMENT, MIE_EXT_DECREMENT_TO_ACC,
    MIE_EXT_INCREMENT, MIE_EXT_INCREMENT_TO_ACC, MIE_EXT_MOVE_TO_ACC,
    MIE_EXT_MOVE_TO_MEM, MIE_EXT_BITWISE_DISJ, MIE_EXT_BITWISE_DISJ_TO_MEMORY,
    MIE_EXT_ROTATE_LEFT
  } mie_op_t;
  typedef enum logic [1:0] {MIE_IDLE, MIE_EXEC, MIE_DUMMY} mie_state_t;
endpackage : mie_pkg
